// ---- srt_pkg.sv ----
// constants, offsets and types shared by the second status register block
// assumes a 32-bit avalon-mm register bus with byte addresses
package srt_pkg;

	// register byte offsets
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_OWN_ADDR   = 8'h04;
	localparam logic [7:0] REG_STATUS     = 8'h18;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h20;
	localparam logic [7:0] REG_IRQ_MASK   = 8'h24;
	localparam logic [7:0] REG_WORD_MASK  = 8'hfc;

	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// control register bits
	localparam int CTRL_ENABLE   = 0;
	localparam int CTRL_ARP      = 1;
	localparam int CTRL_HOST_SEL = 2;
	localparam int CTRL_PEC_EN   = 3;

	// own address register fields
	localparam int OWN_FIRST_OWN_ADDRESS_LSB = 0;
	localparam int OWN_SECOND_OWN_ADDRESS_LSB = 8;
	localparam int OWN_SECOND_OWN_ADDRESS_EN  = 15;

	// status register fields
	localparam int ST_MASTER  = 0;
	localparam int ST_BUSY    = 1;
	localparam int ST_DIR     = 2;
	localparam int ST_GCALL   = 4;
	localparam int ST_SMBDEF  = 5;
	localparam int ST_HOST    = 6;
	localparam int ST_DUAL    = 7;
	localparam int ST_PEC_LSB = 8;

	// interrupt status and mask bits
	localparam int IRQ_W     = 4;
	localparam int IRQ_ADDR  = 0;
	localparam int IRQ_STOP  = 1;
	localparam int IRQ_GCALL = 2;
	localparam int IRQ_ARB   = 3;

	// reserved slave addresses and the packet check polynomial
	localparam logic [7:0] GCALL_BYTE       = 8'h00;
	localparam logic [6:0] SMB_DEFAULT_ADDR = 7'h61;
	localparam logic [6:0] SMB_HOST_ADDR    = 7'h08;
	localparam logic [7:0] CRC_POLY         = 8'h07;

	localparam logic [1:0] SYNC_IDLE  = 2'b11;
	localparam logic [3:0] BIT_LAST   = 4'd7;
	localparam logic [3:0] BIT_ACK    = 4'd8;

	typedef enum logic [2:0] {
		MON_IDLE = 3'b001,
		MON_ADDR = 3'b010,
		MON_DATA = 3'b100
	} srt_mon_e;

endpackage : srt_pkg

// ---- srt_mon_if.sv ----
// carrier between the line monitor and the status register core
// assumes scl and sda are already synchronised to the core clock
`timescale 1ns/1ps
`default_nettype none
interface srt_mon_if;
	logic       scl;
	logic       sda;
	logic       start;
	logic       rstart;
	logic       stop;
	logic       addr_valid;
	logic [7:0] addr_byte;
	logic [7:0] crc;

	modport mon (
		input  scl, sda,
		output start, rstart, stop, addr_valid, addr_byte, crc
	);
	modport core (
		output scl, sda,
		input  start, rstart, stop, addr_valid, addr_byte, crc
	);
endinterface : srt_mon_if
`default_nettype wire

// ---- srt_line_monitor.sv ----
// two-wire line monitor: start, stop, address byte and running crc-8
// assumes synchronised lines; start, rstart, stop and addr_valid are one-cycle registered pulses
`timescale 1ns/1ps
`default_nettype none
module srt_line_monitor (
	input  wire logic i_core_clk, // core clock
	input  wire logic i_rst,      // async reset, active high
	srt_mon_if.mon    bus         // lines in, events out
);
	typedef struct packed {
		srt_pkg::srt_mon_e st;
		logic              scl_q;
		logic              sda_q;
		logic [3:0]        bitcnt;
		logic [7:0]        shreg;
		logic [7:0]        crc;
		logic              start;
		logic              rstart;
		logic              stop;
		logic              addr_valid;
		logic [7:0]        addr_byte;
	} srt_mon_s;

	srt_mon_s r;
	srt_mon_s n;

	function automatic logic [7:0] crc8(input logic [7:0] c_in,
		input logic [7:0] d);
		logic [7:0] c;
		c = c_in;
		for (int i = 7; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? srt_pkg::CRC_POLY : 8'h00);
		end
		return c;
	endfunction : crc8

	always_comb begin
		n = r;
		n.scl_q = bus.scl;
		n.sda_q = bus.sda;
		n.start = 1'b0;
		n.rstart = 1'b0;
		n.stop = 1'b0;
		n.addr_valid = 1'b0;
		if (r.scl_q && bus.scl && r.sda_q && !bus.sda) begin
			n.start = 1'b1;
			n.rstart = (r.st != srt_pkg::MON_IDLE);
			n.st = srt_pkg::MON_ADDR;
			n.bitcnt = 4'h0;
		end else if (r.scl_q && bus.scl && !r.sda_q && bus.sda) begin
			// crc restarts per message, kept across repeated starts
			n.stop = 1'b1;
			n.st = srt_pkg::MON_IDLE;
			n.crc = 8'h00;
		end else if (!r.scl_q && bus.scl && r.st != srt_pkg::MON_IDLE) begin
			if (r.bitcnt == srt_pkg::BIT_ACK) begin
				n.bitcnt = 4'h0;
			end else begin
				n.shreg = {r.shreg[6:0], bus.sda};
				n.bitcnt = 4'(r.bitcnt + 4'h1);
				if (r.bitcnt == srt_pkg::BIT_LAST) begin
					n.crc = crc8(r.crc, {r.shreg[6:0], bus.sda});
					if (r.st == srt_pkg::MON_ADDR) begin
						n.addr_valid = 1'b1;
						n.addr_byte = {r.shreg[6:0], bus.sda};
						n.st = srt_pkg::MON_DATA;
					end
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			r <= '{st: srt_pkg::MON_IDLE, scl_q: 1'b1, sda_q: 1'b1,
				default: '0};
		end else begin
			r <= n;
		end
	end

	assign bus.start = r.start;
	assign bus.rstart = r.rstart;
	assign bus.stop = r.stop;
	assign bus.addr_valid = r.addr_valid;
	assign bus.addr_byte = r.addr_byte;
	assign bus.crc = r.crc;
endmodule : srt_line_monitor
`default_nettype wire

// ---- srt_status_two.sv ----
// second status register of a two-wire controller with avalon-mm access
// assumes scl/sda come from pins; master_go and arb_lost from core logic
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - status register resets to zero and reads at byte offset 0x18.
// - bit 0 reads one in master role, set when master operation starts.
// - master bit clears on stop, arbitration loss or peripheral disabled.
// - bit 1 sets while either line is low, clears after stop.
// - bit 2 follows the read/write bit: one when transmitting.
// - direction bit clears on stop, repeated start, arbitration loss, disable.
// - slave broadcast address hit sets bit 4; stop, restart, disable clear.
// - slave smbus default address hit with resolution sets bit 5.
// - slave smbus host header hit with resolution and host type sets bit 6.
// - bit 7 tells which own address matched, first zero second one.
// - with packet check enabled, bits 15:8 show the running check byte.
module srt_status_two #(
	parameter int ADDR_W = 8 // avalon byte address width
) (
	input  wire logic              i_core_clk,    // core clock, 200 mhz
	input  wire logic              i_rst,         // async reset, high
	input  wire logic [ADDR_W-1:0] i_address,     // avalon byte address
	input  wire logic              i_read,        // avalon read
	input  wire logic              i_write,       // avalon write
	input  wire logic [31:0]       i_writedata,   // avalon write data
	input  wire logic [3:0]        i_byteenable,  // avalon byte lanes
	output logic      [31:0]       o_readdata,    // avalon read data
	output logic                   o_waitrequest, // avalon wait
	input  wire logic              i_scl,         // clock line level
	input  wire logic              i_sda,         // data line level
	input  wire logic              i_master_go,   // master start pulse
	input  wire logic              i_arb_lost,    // arbitration lost pulse
	output logic                   o_irq          // level interrupt
);
	generate
		if (ADDR_W < 8) begin : g_bad_width
			$error("ADDR_W must be at least 8");
		end
	endgenerate

	typedef struct packed {
		logic [1:0]              scl_sync;
		logic [1:0]              sda_sync;
		logic                    en;
		logic                    arp;
		logic                    host_sel;
		logic                    pec_en;
		logic [6:0]              first_own_address;
		logic [6:0]              second_own_address;
		logic                    second_own_address_en;
		logic                    master;
		logic                    busy;
		logic                    dir;
		logic                    gcall;
		logic                    smbdef;
		logic                    host_hit;
		logic                    dual;
		logic [srt_pkg::IRQ_W-1:0] irq_st;
		logic [srt_pkg::IRQ_W-1:0] irq_mask;
		logic                    irq;
		logic                    waitreq;
		logic [31:0]             rdata;
	} srt_core_s;

	srt_core_s r;
	srt_core_s n;

	srt_mon_if mon_if ();

	srt_line_monitor u_mon (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.bus        (mon_if.mon)
	);

	// only the second flop of each synchroniser feeds the line monitor and the busy logic
	assign mon_if.scl = r.scl_sync[1];
	assign mon_if.sda = r.sda_sync[1];

	function automatic logic [15:0] status_word(input srt_core_s s,
		input logic [7:0] crc);
		logic [15:0] w;
		w = srt_pkg::STATUS_RESET;
		w[srt_pkg::ST_MASTER] = s.master;
		w[srt_pkg::ST_BUSY] = s.busy;
		w[srt_pkg::ST_DIR] = s.dir;
		w[srt_pkg::ST_GCALL] = s.gcall;
		w[srt_pkg::ST_SMBDEF] = s.smbdef;
		w[srt_pkg::ST_HOST] = s.host_hit;
		w[srt_pkg::ST_DUAL] = s.dual;
		w[srt_pkg::ST_PEC_LSB +: 8] = s.pec_en ? crc : 8'h00;
		return w;
	endfunction : status_word

	logic [7:0] word_addr;
	logic [6:0] rx_addr;
	logic       rx_rw;
	logic       hit1;
	logic       hit2;
	logic       hit_gc;
	logic       hit_def;
	logic       hit_host;
	logic       slave_hit;
	logic       flag_clr;
	logic [srt_pkg::IRQ_W-1:0] ev;
	logic [srt_pkg::IRQ_W-1:0] w1c;

	always_comb begin
		word_addr = i_address[7:0] & srt_pkg::REG_WORD_MASK;
		rx_addr = mon_if.addr_byte[7:1];
		rx_rw = mon_if.addr_byte[0];
		hit1 = (rx_addr == r.first_own_address);
		hit2 = r.second_own_address_en && (rx_addr == r.second_own_address);
		hit_gc = (mon_if.addr_byte == srt_pkg::GCALL_BYTE);
		hit_def = r.arp && (rx_addr == srt_pkg::SMB_DEFAULT_ADDR);
		hit_host = r.arp && r.host_sel && (rx_addr == srt_pkg::SMB_HOST_ADDR);
		slave_hit = mon_if.addr_valid && !r.master && r.en;
		flag_clr = mon_if.stop || mon_if.rstart || !r.en;
		ev = '0;
		ev[srt_pkg::IRQ_ADDR] = slave_hit &&
			(hit1 || hit2 || hit_gc || hit_def || hit_host);
		ev[srt_pkg::IRQ_STOP] = mon_if.stop;
		ev[srt_pkg::IRQ_GCALL] = slave_hit && hit_gc;
		ev[srt_pkg::IRQ_ARB] = i_arb_lost && r.master;
		w1c = '0;

		n = r;
		n.scl_sync = {r.scl_sync[0], i_scl};
		n.sda_sync = {r.sda_sync[0], i_sda};

		if (mon_if.stop) begin
			n.busy = 1'b0;
		end else if (!r.scl_sync[1] || !r.sda_sync[1]) begin
			n.busy = 1'b1;
		end

		// a start pulse beats a stop seen in the same cycle
		if (!r.en || i_arb_lost) begin
			n.master = 1'b0;
		end else if (i_master_go) begin
			n.master = 1'b1;
		end else if (mon_if.stop) begin
			n.master = 1'b0;
		end

		if (flag_clr || i_arb_lost) begin
			n.dir = 1'b0;
		end else if (mon_if.addr_valid && r.master) begin
			n.dir = !rx_rw;
		end else if (slave_hit && (hit1 || hit2 || hit_gc || hit_def ||
			hit_host)) begin
			n.dir = rx_rw;
		end

		if (flag_clr) begin
			n.gcall = 1'b0;
			n.smbdef = 1'b0;
			n.host_hit = 1'b0;
			n.dual = 1'b0;
		end else if (slave_hit) begin
			n.gcall = r.gcall || hit_gc;
			n.smbdef = r.smbdef || hit_def;
			n.host_hit = r.host_hit || hit_host;
			if (hit2) begin
				n.dual = 1'b1;
			end else if (hit1) begin
				n.dual = 1'b0;
			end
		end

		// one wait cycle, then the answer cycle with waitrequest low
		if (r.waitreq) begin
			if (i_read || i_write) begin
				n.waitreq = 1'b0;
				n.rdata = 32'h0000_0000;
				case (word_addr)
					srt_pkg::REG_CTRL: begin
						n.rdata[srt_pkg::CTRL_ENABLE] = r.en;
						n.rdata[srt_pkg::CTRL_ARP] = r.arp;
						n.rdata[srt_pkg::CTRL_HOST_SEL] = r.host_sel;
						n.rdata[srt_pkg::CTRL_PEC_EN] = r.pec_en;
					end
					srt_pkg::REG_OWN_ADDR: begin
						n.rdata[srt_pkg::OWN_FIRST_OWN_ADDRESS_LSB +: 7] = r.first_own_address;
						n.rdata[srt_pkg::OWN_SECOND_OWN_ADDRESS_LSB +: 7] = r.second_own_address;
						n.rdata[srt_pkg::OWN_SECOND_OWN_ADDRESS_EN] = r.second_own_address_en;
					end
					srt_pkg::REG_STATUS: begin
						n.rdata[15:0] = status_word(r, mon_if.crc);
					end
					srt_pkg::REG_IRQ_STATUS: begin
						n.rdata[srt_pkg::IRQ_W-1:0] = r.irq_st;
					end
					srt_pkg::REG_IRQ_MASK: begin
						n.rdata[srt_pkg::IRQ_W-1:0] = r.irq_mask;
					end
					default: begin
						n.rdata = 32'h0000_0000;
					end
				endcase
			end
		end else begin
			n.waitreq = 1'b1;
			if (i_write) begin
				case (word_addr)
					srt_pkg::REG_CTRL: begin
						if (i_byteenable[0]) begin
							n.en = i_writedata[srt_pkg::CTRL_ENABLE];
							n.arp = i_writedata[srt_pkg::CTRL_ARP];
							n.host_sel = i_writedata[srt_pkg::CTRL_HOST_SEL];
							n.pec_en = i_writedata[srt_pkg::CTRL_PEC_EN];
						end
					end
					srt_pkg::REG_OWN_ADDR: begin
						if (i_byteenable[0]) begin
							n.first_own_address = i_writedata[srt_pkg::OWN_FIRST_OWN_ADDRESS_LSB +: 7];
						end
						if (i_byteenable[1]) begin
							n.second_own_address = i_writedata[srt_pkg::OWN_SECOND_OWN_ADDRESS_LSB +: 7];
							n.second_own_address_en = i_writedata[srt_pkg::OWN_SECOND_OWN_ADDRESS_EN];
						end
					end
					srt_pkg::REG_IRQ_STATUS: begin
						if (i_byteenable[0]) begin
							w1c = i_writedata[srt_pkg::IRQ_W-1:0];
						end
					end
					srt_pkg::REG_IRQ_MASK: begin
						if (i_byteenable[0]) begin
							n.irq_mask = i_writedata[srt_pkg::IRQ_W-1:0];
						end
					end
					default: begin
						// status and unmapped words ignore writes
						n.rdata = r.rdata;
					end
				endcase
			end
		end

		// a new event in the clearing cycle stays set
		n.irq_st = (r.irq_st & ~w1c) | ev;
		n.irq = |(n.irq_st & n.irq_mask);
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			r <= '{scl_sync: srt_pkg::SYNC_IDLE, sda_sync: srt_pkg::SYNC_IDLE,
				waitreq: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	assign o_readdata = r.rdata;
	assign o_waitrequest = r.waitreq;
	assign o_irq = r.irq;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_req;
		r.waitreq && (i_read || i_write);
	endsequence

	sequence s_status_read;
		r.waitreq && i_read && (word_addr == srt_pkg::REG_STATUS);
	endsequence

	bus_answer_a: assert property (
		s_req |=> !o_waitrequest ##1 o_waitrequest)
		else $error("bus answer not given in one cycle");
	status_read_a: assert property (s_status_read |=>
		o_readdata[15:0] == status_word($past(r), $past(mon_if.crc)))
		else $error("status read data wrong");
	master_set_a: assert property (i_master_go && r.en &&
		!i_arb_lost |=> r.master)
		else $error("master bit not set");
	master_clear_a: assert property (
		(!r.en || i_arb_lost) |=> !r.master)
		else $error("master bit not cleared");
	busy_low_a: assert property (!mon_if.stop &&
		(!mon_if.scl || !mon_if.sda) |=>
		r.busy ##1 (r.busy || $past(mon_if.stop)))
		else $error("busy bit not set by low line");
	busy_stop_a: assert property (mon_if.stop |=> !r.busy)
		else $error("busy bit not cleared after stop");
	dir_slave_a: assert property (slave_hit && hit1 &&
		!flag_clr && !i_arb_lost |=> r.dir == $past(rx_rw))
		else $error("direction bit does not follow rw");
	dir_clear_a: assert property (
		(mon_if.rstart || mon_if.stop) |=> !r.dir)
		else $error("direction bit not cleared");
	gcall_hit_a: assert property (slave_hit && hit_gc &&
		!flag_clr |=> r.gcall ##1 (r.gcall || $past(flag_clr)))
		else $error("broadcast flag not set");
	flags_clear_a: assert property (flag_clr |=>
		!r.gcall && !r.smbdef && !r.host_hit && !r.dual)
		else $error("match flags not cleared");
	host_gate_a: assert property (!r.arp |=>
		!$rose(r.smbdef) && !$rose(r.host_hit))
		else $error("smbus flag set without resolution enabled");
	dual_hit_a: assert property (slave_hit && hit2 &&
		!flag_clr |=> r.dual)
		else $error("second address flag not set");
	pec_view_a: assert property (s_status_read ##0 !r.pec_en |=>
		o_readdata[15:8] == 8'h00)
		else $error("check byte shown while disabled");
	reserved_zero_a: assert property (s_status_read |=>
		!o_readdata[3] && o_readdata[31:16] == 16'h0000)
		else $error("reserved status bit reads one");
endmodule : srt_status_two
`default_nettype wire

// ---- srt_bus_model.sv ----
// far-side two-wire bus driver: start, restart, stop and address bytes
// assumes the core clock paces it; lines idle high through the pull-ups
`timescale 1ns/1ps
`default_nettype none
module srt_bus_model #(
	parameter int HALF = 16 // core clocks per half link period, 80 ns
) (
	input  wire logic i_core_clk, // pacing clock
	output logic      o_scl,      // clock line level
	output logic      o_sda       // data line level
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask : hold
	// sda falls only while scl is high, so this also serves as a restart
	task automatic start_cond();
		o_sda <= 1'b1;
		hold(HALF / 2);
		o_scl <= 1'b1;
		hold(HALF / 2);
		o_sda <= 1'b0;
		hold(HALF / 2);
		o_scl <= 1'b0;
		hold(HALF / 2);
	endtask : start_cond
	// msb first, then a ninth clock with sda released: nobody acknowledges
	task automatic byte_out(input logic [7:0] b);
		for (int i = 8; i >= 0; i--) begin
			o_sda <= (i == 0) ? 1'b1 : b[i-1];
			hold(HALF / 2);
			o_scl <= 1'b1;
			hold(HALF);
			o_scl <= 1'b0;
			hold(HALF / 2);
		end
	endtask : byte_out
	// scl stays high after the stop: the link clock stands still when idle
	task automatic stop_cond();
		o_sda <= 1'b0;
		hold(HALF / 2);
		o_scl <= 1'b1;
		hold(HALF / 2);
		o_sda <= 1'b1;
		hold(HALF);
	endtask : stop_cond
endmodule : srt_bus_model
`default_nettype wire

// ---- srt_status_two_tb.sv ----
// self-checking bench for the second status register block
// assumes the far side is srt_bus_model; the bench acts as bus master
`timescale 1ns/1ps
`default_nettype none
module srt_status_two_tb;
	localparam logic [7:0]  HIT_BYTE [4] = '{8'h00, 8'hc2, 8'h10, 8'h25};
	localparam logic [31:0] HIT_EXP  [4] = '{32'h12, 32'h22, 32'h42, 32'h06};
	logic        i_core_clk;
	logic        i_rst;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        scl;
	logic        sda;
	logic        master_go;
	logic        arb_lost;
	logic        irq;
	logic [31:0] exp_st;
	int          failures;
	int          check_count;
	int          cyc;

	srt_status_two u_srt_status_two (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_address(address), .i_read(read), .i_write(write),
		.i_writedata(writedata), .i_byteenable(4'hf),
		.o_readdata(readdata), .o_waitrequest(waitrequest), .i_scl(scl),
		.i_sda(sda), .i_master_go(master_go), .i_arb_lost(arb_lost),
		.o_irq(irq));
	srt_bus_model u_srt_bus_model (.i_core_clk(i_core_clk), .o_scl(scl),
		.o_sda(sda));

	always #2.5 i_core_clk = ~i_core_clk;

	function automatic logic [7:0] crc8(input logic [7:0] d);
		logic [7:0] c;
		c = d;
		for (int i = 0; i < 8; i++)
			c = c[7] ? ((c << 1) ^ srt_pkg::CRC_POLY) : (c << 1);
		return c;
	endfunction : crc8

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// request held until waitrequest is sampled low; only the run timeout
	// ends a wait that never finishes
	task automatic access(input logic [7:0] a, input logic wr_n_rd,
		input logic [31:0] d);
		@(posedge i_core_clk);
		address <= a;
		writedata <= d;
		write <= wr_n_rd;
		read <= ~wr_n_rd;
		do begin
			@(posedge i_core_clk);
		end while (waitrequest !== 1'b0);
		exp_st = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : access

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		access(a, 1'b1, d);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [31:0] e);
		access(a, 1'b0, 32'h0);
		chk(what, e, exp_st);
	endtask : rd_chk

	task automatic pulse(input logic arb);
		@(posedge i_core_clk);
		master_go <= ~arb;
		arb_lost <= arb;
		@(posedge i_core_clk);
		master_go <= 1'b0;
		arb_lost <= 1'b0;
	endtask : pulse

	task automatic irq_chk(input logic e);
		repeat (3) @(posedge i_core_clk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask : irq_chk

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	initial begin
		{i_core_clk, read, write, master_go, arb_lost} = '0;
		{address, writedata, failures, check_count, cyc} = '0;
		i_rst = 1'b1;
		repeat (10) @(posedge i_core_clk);
		i_rst <= 1'b0;
		rd_chk("status reset", srt_pkg::REG_STATUS, 32'h0);
		wr(srt_pkg::REG_STATUS, 32'hffff_ffff);
		rd_chk("status kept", srt_pkg::REG_STATUS, 32'h0);
		rd_chk("unmapped", 8'h10, 32'h0);
		$display("test reset done");
		wr(srt_pkg::REG_OWN_ADDR, 32'h0000_b412);
		wr(srt_pkg::REG_CTRL, 32'h9);
		u_srt_bus_model.start_cond();
		u_srt_bus_model.byte_out(8'h69);
		rd_chk("second hit", srt_pkg::REG_STATUS,
			{16'h0, crc8(8'h69), 8'h86});
		wr(srt_pkg::REG_STATUS, 32'h0);
		rd_chk("flags kept", srt_pkg::REG_STATUS,
			{16'h0, crc8(8'h69), 8'h86});
		u_srt_bus_model.start_cond();
		rd_chk("restart", srt_pkg::REG_STATUS,
			{16'h0, crc8(8'h69), 8'h02});
		u_srt_bus_model.stop_cond();
		rd_chk("stop", srt_pkg::REG_STATUS, 32'h0);
		$display("test second address done");
		wr(srt_pkg::REG_CTRL, 32'h7);
		for (int i = 0; i < 4; i++) begin
			u_srt_bus_model.start_cond();
			u_srt_bus_model.byte_out(HIT_BYTE[i]);
			rd_chk("hit", srt_pkg::REG_STATUS, HIT_EXP[i]);
			u_srt_bus_model.stop_cond();
			rd_chk("hit cleared", srt_pkg::REG_STATUS, 32'h0);
		end
		u_srt_bus_model.start_cond();
		u_srt_bus_model.byte_out(8'h00);
		wr(srt_pkg::REG_CTRL, 32'h0);
		rd_chk("disable", srt_pkg::REG_STATUS, 32'h2);
		u_srt_bus_model.stop_cond();
		$display("test slave hits done");
		wr(srt_pkg::REG_CTRL, 32'h1);
		pulse(1'b0);
		rd_chk("master", srt_pkg::REG_STATUS, 32'h1);
		u_srt_bus_model.start_cond();
		u_srt_bus_model.byte_out(8'h24);
		rd_chk("master tx", srt_pkg::REG_STATUS, 32'h7);
		pulse(1'b1);
		rd_chk("arb lost", srt_pkg::REG_STATUS, 32'h2);
		u_srt_bus_model.stop_cond();
		pulse(1'b0);
		wr(srt_pkg::REG_CTRL, 32'h0);
		rd_chk("master off", srt_pkg::REG_STATUS, 32'h0);
		wr(srt_pkg::REG_CTRL, 32'h1);
		pulse(1'b0);
		u_srt_bus_model.start_cond();
		u_srt_bus_model.stop_cond();
		rd_chk("master stop", srt_pkg::REG_STATUS, 32'h0);
		$display("test master done");
		irq_chk(1'b0);
		wr(srt_pkg::REG_IRQ_MASK, 32'h2);
		irq_chk(1'b1);
		rd_chk("irq status", srt_pkg::REG_IRQ_STATUS, 32'hf);
		wr(srt_pkg::REG_IRQ_STATUS, 32'h2);
		irq_chk(1'b0);
		rd_chk("irq cleared", srt_pkg::REG_IRQ_STATUS, 32'hd);
		$display("test interrupt done");
		report_and_stop();
	end
endmodule : srt_status_two_tb
`default_nettype wire
